//--- core/clock_gen_i2c_master.sv
// Bus master end: runs write and pointer-then-read frames
`include "clock_gen_i2c_regs.svh"

module clock_gen_i2c_master
#(
  parameter int unsigned QTR_CYC = `SCL_QTR_CYC  // Quarter bit time
)
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  i2c_link_if.host                    link,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire logic                   cmd_rd,
  input  wire clock_gen_i2c_pkg::tid_t  cmd_id,
  input  wire clock_gen_i2c_pkg::byte_t cmd_ptr,
  input  wire clock_gen_i2c_pkg::byte_t cmd_len,
  input  wire clock_gen_i2c_pkg::byte_t tx_data,
  output logic                        tx_take,
  output logic                        rx_valid,
  output clock_gen_i2c_pkg::byte_t    rx_data,
  output logic                        done,
  output logic                        nack_err
);
  import clock_gen_i2c_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [1:0]  sda_sync_ff;       // SDA synchroniser
  logic [15:0] qcnt_ff;           // Quarter bit timer
  logic [1:0]  phase_ff;          // Quarter within a bit
  logic [3:0]  bit_ff;            // Bit within nine-clock slot
  mst_state_e  hstate_ff;         // Bit engine state
  mst_seg_e    seg_ff;            // Byte role
  byte_t       txb_ff;            // Byte being sent
  byte_t       rxb_ff;            // Byte being received
  byte_t       len_ff;            // Data bytes left
  logic        rd_ff;             // Frame is a read
  tid_t        id_ff;             // Target identifier
  logic        ack_bad_ff;        // Target left SDA high in ack slot
  logic        scl_oe_ff;         // Pull SCL low
  logic        sda_oe_ff;         // Pull SDA low
  logic        cmd_ready_ff;
  logic        tx_take_ff;
  logic        rx_valid_ff;
  byte_t       rx_data_ff;
  logic        done_ff;
  logic        nack_err_ff;

  // Decode
  wire         sda_s  = sda_sync_ff[1];
  wire         qtick  = qcnt_ff == 16'(QTR_CYC - 1);
  wire         rx_seg = seg_ff == SG_RD;
  wire         last   = len_ff == 8'h01;
  wire         ackbit = bit_ff == `ACK_BIT;

  // ---------------------------------------------------------------
  // Bit engine, one step per quarter bit
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sda_sync_ff <= 2'h3;
      qcnt_ff <= 16'h0000;
      phase_ff <= 2'h0;
      bit_ff <= 4'h0;
      hstate_ff <= H_IDLE;
      seg_ff <= SG_AW;
      txb_ff <= 8'h00;
      rxb_ff <= 8'h00;
      len_ff <= 8'h00;
      rd_ff <= 1'b0;
      id_ff <= 7'h00;
      ack_bad_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      tx_take_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      done_ff <= 1'b0;
      nack_err_ff <= 1'b0;
    end
    else
    begin
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
      tx_take_ff  <= 1'b0;
      rx_valid_ff <= 1'b0;
      done_ff     <= 1'b0;
      // Bit rate capped by the quarter timer
      qcnt_ff <= (qtick || hstate_ff == H_IDLE) ? 16'h0000
                 : qcnt_ff + 16'h0001;
      case (hstate_ff)
        H_IDLE:
        begin
          cmd_ready_ff <= 1'b1;
          if (cmd_valid && cmd_ready_ff)
          begin
            cmd_ready_ff <= 1'b0;
            nack_err_ff  <= 1'b0;
            rd_ff  <= cmd_rd;
            id_ff  <= cmd_id;
            len_ff <= cmd_len;
            txb_ff <= cmd_ptr;
            rxb_ff <= cmd_ptr;   // Pointer parked until id is sent
            seg_ff <= SG_AW;
            phase_ff  <= 2'h0;
            hstate_ff <= H_START;
          end
        end
        H_START:
          if (qtick)
          begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0:
              begin
                scl_oe_ff <= 1'b1;
                sda_oe_ff <= 1'b0;
              end
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b1;
              default:
              begin
                // Id byte with direction follows every start
                scl_oe_ff <= 1'b1;
                bit_ff    <= 4'h0;
                txb_ff    <= {id_ff, seg_ff == SG_AR};
                hstate_ff <= H_BIT;
              end
            endcase
          end
        H_BIT:
          if (qtick)
          begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0:
                // Set SDA while SCL is low; ack all but last read
                sda_oe_ff <= ackbit ? (rx_seg && !last)
                             : (!rx_seg && !txb_ff[7]);
              2'h1: scl_oe_ff <= 1'b0;
              2'h2:
                if (ackbit)
                  ack_bad_ff <= sda_s;
                else if (rx_seg)
                  // Only read bytes shift in; keeps the parked pointer
                  rxb_ff <= {rxb_ff[6:0], sda_s};
              default:
              begin
                scl_oe_ff <= 1'b1;
                txb_ff    <= {txb_ff[6:0], 1'b0};
                bit_ff    <= bit_ff + 4'h1;
                if (ackbit)
                begin
                  bit_ff <= 4'h0;
                  case (seg_ff)
                    SG_AW:
                    begin
                      seg_ff <= SG_PTR;
                      txb_ff <= rxb_ff;
                    end
                    SG_PTR:
                      if (!ack_bad_ff && len_ff != 8'h00 && rd_ff)
                      begin
                        seg_ff    <= SG_AR;
                        phase_ff  <= 2'h0;
                        hstate_ff <= H_START;
                      end
                      else
                      begin
                        seg_ff     <= SG_WD;
                        txb_ff     <= tx_data;
                        tx_take_ff <= 1'b1;
                      end
                    SG_AR: seg_ff <= SG_RD;
                    SG_WD: len_ff <= len_ff - 8'h01;
                    default:
                    begin
                      rx_valid_ff <= 1'b1;
                      rx_data_ff  <= rxb_ff;
                      len_ff      <= len_ff - 8'h01;
                    end
                  endcase
                  // Frame ends on a refusal or after the last byte
                  if (ack_bad_ff && !rx_seg)
                    nack_err_ff <= 1'b1;
                  if ((ack_bad_ff && !rx_seg)
                      || (seg_ff == SG_PTR && len_ff == 8'h00)
                      || ((seg_ff == SG_WD || rx_seg) && last))
                  begin
                    tx_take_ff <= 1'b0;
                    hstate_ff  <= H_STOP;
                  end
                  else if (seg_ff == SG_WD)
                  begin
                    txb_ff     <= tx_data;
                    tx_take_ff <= 1'b1;
                  end
                end
              end
            endcase
          end
        default:
          if (qtick)
          begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0:
              begin
                scl_oe_ff <= 1'b1;
                sda_oe_ff <= 1'b1;
              end
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b0;
              default:
              begin
                done_ff   <= 1'b1;
                hstate_ff <= H_IDLE;
              end
            endcase
          end
      endcase
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_ff;
  assign link.host_sda_oe = sda_oe_ff;
  assign cmd_ready = cmd_ready_ff;
  assign tx_take   = tx_take_ff;
  assign rx_valid  = rx_valid_ff;
  assign rx_data   = rx_data_ff;
  assign done      = done_ff;
  assign nack_err  = nack_err_ff;

endmodule : clock_gen_i2c_master

//--- core/clock_gen_i2c_pkg.sv
// Types shared by both ends of the configuration link
package clock_gen_i2c_pkg;

  typedef logic [7:0] byte_t;   // One link byte
  typedef logic [6:0] tid_t;    // Target identifier field

  // Target byte parser
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } tgt_state_e;

  // Master bit engine
  typedef enum logic [1:0]
  {
    H_IDLE,
    H_START,
    H_BIT,
    H_STOP
  } mst_state_e;

  // Master byte role within a frame
  typedef enum logic [2:0]
  {
    SG_AW,
    SG_PTR,
    SG_WD,
    SG_AR,
    SG_RD
  } mst_seg_e;

endpackage : clock_gen_i2c_pkg

//--- core/clock_gen_i2c_regs.svh
// Constants for the two-wire configuration port and its bus master
//
// Notes on behaviour
// - Transfers both ways at up to 400 kbit/s.
// - Write: start, id, W, pointer, data, acks.
// - Data bytes stored at pointer, then pointer+1.
// - SDA changes only while SCL is low.
// - SDA falling, SCL high: start, reparse id.
// - SDA rising, SCL high: stop, go idle.
// - After start: id byte, pointer, then data.
// - New pointer or target needs stop, start; here the read frame uses a repeated start with no stop.
// - Target acknowledges every byte in write mode.
// - Master acknowledges read bytes; target releases SDA.
`ifndef CLOCK_GEN_I2C_REGS_SVH
`define CLOCK_GEN_I2C_REGS_SVH

// ---------------------------------------------------------------
// Link timing
// ---------------------------------------------------------------
`define LINK_MAX_KBPS    400
`define MCLK_MHZ         100
// Quarter bit time in mclk cycles, rounded up (least time)
`define SCL_QTR_CYC \
  ((1000 * `MCLK_MHZ + 4 * `LINK_MAX_KBPS - 1) / (4 * `LINK_MAX_KBPS))

// ---------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------
`define LAST_DATA_BIT    4'h7
`define ACK_BIT          4'h8
`define DIR_WRITE        1'b0
`define DIR_READ         1'b1
// Arbitrary target identifier, not tied to any real part
`define TGT_ID_DEFAULT   7'h2a
`define CFG_RESET_VAL    8'h00

`endif

//--- core/clock_gen_i2c_target.sv
// Configuration port target: link parser, register array, write feed
`include "clock_gen_i2c_regs.svh"

module clock_gen_i2c_target
#(
  parameter logic [6:0] TARGET_ID_FIELD = `TGT_ID_DEFAULT  // Arbitrary id
)
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  i2c_link_if.target                  link,
  output logic                        cfg_wr_valid,
  output clock_gen_i2c_pkg::byte_t    cfg_wr_addr,
  output clock_gen_i2c_pkg::byte_t    cfg_wr_data,
  output logic                        frame_done
);
  import clock_gen_i2c_pkg::*;

  // ---------------------------------------------------------------
  // Link reset
  // ---------------------------------------------------------------
  logic        rst_lnk_ff;        // Reset for SCL and SDA edge logic

  // SCL may stand still, so the link side takes reset asynchronously
  always_ff @(posedge mclk)
  begin
    rst_lnk_ff <= sys_rst;
  end

  // ---------------------------------------------------------------
  // Start and stop detection
  // ---------------------------------------------------------------
  logic        start_tgl_ff;      // Flips on each start
  logic        stop_tgl_ff;       // Flips on each stop

  // SDA falling while SCL high marks a start
  always_ff @(negedge link.sda or posedge rst_lnk_ff)
  begin
    if (rst_lnk_ff)
      start_tgl_ff <= 1'b0;
    else if (link.scl)
      start_tgl_ff <= ~start_tgl_ff;
  end

  // SDA rising while SCL high marks a stop
  always_ff @(posedge link.sda or posedge rst_lnk_ff)
  begin
    if (rst_lnk_ff)
      stop_tgl_ff <= 1'b0;
    else if (link.scl)
      stop_tgl_ff <= ~stop_tgl_ff;
  end

  // ---------------------------------------------------------------
  // Byte parser, SCL rising edge
  // ---------------------------------------------------------------
  tgt_state_e  state_ff;          // Current byte role
  tgt_state_e  pend_state_ff;     // Role taken after the ack slot
  logic        start_ack_ff;      // Last start seen by parser
  logic        stop_ack_ff;       // Last stop seen by parser
  logic [3:0]  bit_cnt_ff;        // Clock within nine-clock slot
  logic [6:0]  shift_ff;          // Bits received so far
  logic        ack_pend_ff;       // Target acks this slot
  byte_t       register_pointer_ff;  // Next register to access
  byte_t       tx_ff;             // Byte being returned
  logic        wr_tgl_ff;         // Flips on each stored byte
  byte_t       wr_addr_l_ff;      // Address of last stored byte
  byte_t       wr_data_l_ff;      // Value of last stored byte
  byte_t       regs_mem [0:255];  // Configuration registers

  // Decode of the current link clock
  wire         start_seen = start_tgl_ff != start_ack_ff;
  wire         stop_seen  = stop_tgl_ff != stop_ack_ff;
  wire byte_t  rx_byte    = {shift_ff, link.sda};
  wire         byte_end   = bit_cnt_ff == `LAST_DATA_BIT;
  wire         ack_slot   = bit_cnt_ff == `ACK_BIT;
  wire         id_match   = rx_byte[7:1] == TARGET_ID_FIELD;
  wire         mst_nack   = link.sda;
  wire byte_t  ptr_inc    = register_pointer_ff + 8'h01;

  // Sample SDA while SCL is high and step through the frame
  always_ff @(posedge link.scl or posedge rst_lnk_ff)
  begin
    if (rst_lnk_ff)
    begin
      state_ff            <= ST_IDLE;
      pend_state_ff       <= ST_IDLE;
      start_ack_ff        <= 1'b0;
      stop_ack_ff         <= 1'b0;
      bit_cnt_ff          <= 4'h0;
      shift_ff            <= 7'h00;
      ack_pend_ff         <= 1'b0;
      register_pointer_ff <= 8'h00;
      tx_ff               <= 8'h00;
      wr_tgl_ff           <= 1'b0;
      wr_addr_l_ff        <= 8'h00;
      wr_data_l_ff        <= 8'h00;
      for (int i = 0; i < 256; i++)
        regs_mem[i] <= `CFG_RESET_VAL;
    end
    else
    begin
      start_ack_ff <= start_tgl_ff;
      stop_ack_ff  <= stop_tgl_ff;
      if (start_seen)
      begin
        // First clock after a start is the id byte's top bit
        state_ff    <= ST_ADDR;
        shift_ff    <= {6'h00, link.sda};
        bit_cnt_ff  <= 4'h1;
        ack_pend_ff <= 1'b0;
      end
      else if (stop_seen)
      begin
        // Stray clock after a stop: stay idle
        state_ff    <= ST_IDLE;
        bit_cnt_ff  <= 4'h0;
        ack_pend_ff <= 1'b0;
      end
      else
      begin
        shift_ff   <= {shift_ff[5:0], link.sda};
        bit_cnt_ff <= ack_slot ? 4'h0 : bit_cnt_ff + 4'h1;
        if (byte_end)
        begin
          // Eighth data bit: decide what the byte means
          case (state_ff)
            ST_ADDR:
            begin
              ack_pend_ff <= id_match;
              if (!id_match)
                pend_state_ff <= ST_IGNORE;
              else if (rx_byte[0] == `DIR_READ)
                pend_state_ff <= ST_RDATA;
              else
                pend_state_ff <= ST_PTR;
            end
            ST_PTR:
            begin
              register_pointer_ff <= rx_byte;
              ack_pend_ff         <= 1'b1;
              pend_state_ff       <= ST_WDATA;
            end
            ST_WDATA:
            begin
              // Store and move on to the next register
              regs_mem[register_pointer_ff] <= rx_byte;
              register_pointer_ff <= ptr_inc;
              wr_addr_l_ff        <= register_pointer_ff;
              wr_data_l_ff        <= rx_byte;
              wr_tgl_ff           <= ~wr_tgl_ff;
              ack_pend_ff         <= 1'b1;
              pend_state_ff       <= ST_WDATA;
            end
            default:
            begin
              // Read, idle and foreign frames give no ack
              ack_pend_ff   <= 1'b0;
              pend_state_ff <= state_ff;
            end
          endcase
        end
        if (ack_slot)
        begin
          ack_pend_ff <= 1'b0;
          if (state_ff == ST_RDATA && mst_nack)
            state_ff <= ST_IGNORE;
          else
          begin
            state_ff <= pend_state_ff;
            // Fetch next byte to return
            if (pend_state_ff == ST_RDATA)
            begin
              tx_ff               <= regs_mem[register_pointer_ff];
              register_pointer_ff <= ptr_inc;
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // SDA drive, SCL falling edge
  // ---------------------------------------------------------------
  logic        drive_low_ff;      // Target pulls SDA low
  logic        sda_o_ff;          // Open-drain drive value

  wire [2:0]   tx_idx = 3'(`LAST_DATA_BIT - bit_cnt_ff);
  wire         rd_low = state_ff == ST_RDATA && !ack_slot
                      && !tx_ff[tx_idx];
  wire         nxt_drive_low = (ack_slot && ack_pend_ff) || rd_low;

  // SDA only moves while SCL is low
  always_ff @(negedge link.scl or posedge rst_lnk_ff)
  begin
    if (rst_lnk_ff)
    begin
      drive_low_ff <= 1'b0;
      sda_o_ff     <= 1'b0;
    end
    else
    begin
      // Ack slot in read mode left released
      drive_low_ff <= nxt_drive_low;
      sda_o_ff     <= 1'b0;
    end
  end

  assign link.dev_sda_o  = sda_o_ff;
  assign link.dev_sda_oe = drive_low_ff;

  // ---------------------------------------------------------------
  // Crossing to mclk
  // ---------------------------------------------------------------
  logic [2:0]  wr_sync_ff;        // Store toggle synchroniser
  logic [2:0]  stop_sync_ff;      // Stop toggle synchroniser
  logic        cfg_wr_valid_ff;   // One-cycle store notice
  byte_t       cfg_wr_addr_ff;    // Stored register address
  byte_t       cfg_wr_data_ff;    // Stored register value
  logic        frame_done_ff;     // One-cycle stop notice

  // Toggle edges past the first two stages
  wire         wr_edge   = wr_sync_ff[2] ^ wr_sync_ff[1];
  wire         stop_edge = stop_sync_ff[2] ^ stop_sync_ff[1];

  // Address and data are steady for many SCL periods per toggle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_sync_ff      <= 3'h0;
      stop_sync_ff    <= 3'h0;
      cfg_wr_valid_ff <= 1'b0;
      cfg_wr_addr_ff  <= 8'h00;
      cfg_wr_data_ff  <= 8'h00;
      frame_done_ff   <= 1'b0;
    end
    else
    begin
      wr_sync_ff      <= {wr_sync_ff[1:0], wr_tgl_ff};
      stop_sync_ff    <= {stop_sync_ff[1:0], stop_tgl_ff};
      cfg_wr_valid_ff <= wr_edge;
      frame_done_ff   <= stop_edge;
      if (wr_edge)
      begin
        cfg_wr_addr_ff <= wr_addr_l_ff;
        cfg_wr_data_ff <= wr_data_l_ff;
      end
    end
  end

  assign cfg_wr_valid = cfg_wr_valid_ff;
  assign cfg_wr_addr  = cfg_wr_addr_ff;
  assign cfg_wr_data  = cfg_wr_data_ff;
  assign frame_done   = frame_done_ff;

endmodule : clock_gen_i2c_target

//--- core/i2c_link_if.sv
// Open-drain two-wire link joining master and target
interface i2c_link_if;

  logic host_scl_o;    // Master SCL drive value
  logic host_scl_oe;   // Master drives SCL
  logic host_sda_o;    // Master SDA drive value
  logic host_sda_oe;   // Master drives SDA
  logic dev_sda_o;     // Target SDA drive value
  logic dev_sda_oe;    // Target drives SDA
  logic scl;           // Resolved SCL, pulled up
  logic sda;           // Resolved SDA, pulled up

  // Wired-AND with pull-up
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1)
             & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host
  (
    input  scl,
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );

  modport target
  (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

endinterface : i2c_link_if

//--- testbench/clock_gen_i2c_link_props.sv
// Link checker: framing, acknowledge and release behaviour on the wires
module clock_gen_i2c_link_props
#(
  parameter logic [6:0] TGT_ID = 7'h2a  // Arbitrary id
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------------------------
  // Bit tracker
  // ----------------------------------------------------------
  logic       scl_q_ff;  // Last SCL
  logic       sda_q_ff;  // Last SDA
  logic [3:0] cnt_ff;    // Bit slot in byte
  logic [7:0] sh_ff;     // Bits seen
  logic       first_ff;  // In id byte
  logic       wr_ff;     // Write frame
  logic       ign_ff;    // Foreign frame
  logic [7:0] per_ff;    // Cycles since SCL rise, saturating
  wire start_w = scl && scl_q_ff && sda_q_ff && !sda;
  wire stop_w  = scl && scl_q_ff && !sda_q_ff && sda;
  wire rise_w  = scl && !scl_q_ff;
  wire ack_w   = rise_w && (cnt_ff == 4'h8);
  // Times SCL periods for the bit rate limit
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      per_ff <= 8'hff;
    else if (rise_w)
      per_ff <= 8'h00;
    else if (per_ff != 8'hff)
      per_ff <= per_ff + 8'h01;
  end
  // Counts rises since start, decodes id byte
  always_ff @(posedge mclk)
  begin
    scl_q_ff <= scl;
    sda_q_ff <= sda;
    if (sys_rst || start_w)
    begin
      cnt_ff <= 4'h0;
      first_ff <= 1'b1;
      wr_ff <= 1'b0;
      ign_ff <= 1'b0;
    end
    else if (rise_w)
    begin
      sh_ff <= {sh_ff[6:0], sda};
      cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
      if (ack_w && first_ff)
      begin
        first_ff <= 1'b0;
        wr_ff <= !sh_ff[0];
        ign_ff <= (sh_ff[7:1] != TGT_ID);
      end
    end
  end
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_dev_stable_high:
    assert property (scl && scl_q_ff |-> $stable(dev_sda_oe))
    else $error("target SDA moved while SCL high");
  a_scl_low_min:
    assert property ($fell(scl) |-> !scl[*3])
    else $error("SCL low phase too short");
  a_scl_rate_max:
    assert property (rise_w |-> per_ff >= 8'hf9)
    else $error("SCL period shorter than 400 kbit/s allows");
  a_quiet_after_reset:
    assert property ($fell(sys_rst) |->
      !dev_sda_oe && !host_scl_oe && !host_sda_oe)
    else $error("link driven right after reset");
  a_start_quiet:
    assert property (start_w |-> !dev_sda_oe[*8])
    else $error("target drives SDA after start");
  a_stop_quiet:
    assert property (stop_w |-> !dev_sda_oe[*8])
    else $error("target drives SDA after stop");
  a_id_ack:
    assert property (ack_w && first_ff && sh_ff[7:1] == TGT_ID |-> !sda)
    else $error("own id not acknowledged");
  a_data_ack:
    assert property (ack_w && !first_ff && wr_ff && !ign_ff |-> !sda)
    else $error("write byte not acknowledged");
  a_read_release:
    assert property (ack_w && !first_ff && !wr_ff |-> !dev_sda_oe)
    else $error("target holds SDA in master ack slot");
  a_foreign_quiet:
    assert property (ign_ff |-> !dev_sda_oe)
    else $error("target drives SDA in foreign frame");
endmodule : clock_gen_i2c_link_props

//--- testbench/tb_top.sv
// Self-checking bench: master and target joined over the link
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_gen_i2c_pkg::*;
  localparam tid_t TID = 7'h35;  // Arbitrary target id
  logic  mclk, sys_rst, cmd_valid, cmd_ready, cmd_rd, tx_take, rx_valid;
  logic  done, nack_err, cfg_wr_valid, frame_done;
  tid_t  cmd_id;
  byte_t cmd_ptr, cmd_len, tx_data, rx_data, cfg_wr_addr, cfg_wr_data;
  byte_t ptr, len;
  int    num_errors, total_checks, seed, fd_cnt, b, a;
  int    mem [256];               // Register model
  int    txq[$], rxq[$], wrq[$];  // Bytes to send, to read, to store
  i2c_link_if link();
  // Default quarter keeps SCL within the 400 kbit/s limit
  clock_gen_i2c_master i_clock_gen_i2c_master(
    .mclk(mclk), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_rd(cmd_rd), .cmd_id(cmd_id),
    .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .tx_data(tx_data),
    .tx_take(tx_take), .rx_valid(rx_valid), .rx_data(rx_data),
    .done(done), .nack_err(nack_err));
  clock_gen_i2c_target #(.TARGET_ID_FIELD(TID)) i_clock_gen_i2c_target(
    .mclk(mclk), .sys_rst(sys_rst), .link(link),
    .cfg_wr_valid(cfg_wr_valid), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .frame_done(frame_done));
  clock_gen_i2c_link_props #(.TGT_ID(TID)) i_clock_gen_i2c_link_props(
    .mclk(mclk), .sys_rst(sys_rst), .host_scl_oe(link.host_scl_oe),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
    .scl(link.scl), .sda(link.sda));
  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Compares one value and counts it
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Prints counts and verdict, ends the run
  task automatic test_done();
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // Issues one command and waits for its end
  task automatic run_cmd(input logic rd, input tid_t id,
                         input byte_t p, input byte_t n);
    int w;
    w = 0;
    fd_cnt = 0;
    if (txq.size() > 0) tx_data <= byte_t'(txq[0]);
    cmd_valid <= 1'b1;
    cmd_rd <= rd;
    cmd_id <= id;
    cmd_ptr <= p;
    cmd_len <= n;
    @(posedge mclk);
    while (cmd_ready !== 1'b1) @(posedge mclk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && w < 16000)
    begin
      @(posedge mclk);
      w++;
    end
    check("done", done, 1'b1);
    repeat (8) @(posedge mclk);
    check("frame_done", 16'(fd_cnt), 16'h0001);
  endtask : run_cmd
  // Monitors: stores, read bytes, stops, write feed
  always @(posedge mclk)
  begin
    if (frame_done === 1'b1) fd_cnt++;
    if (tx_take === 1'b1 && txq.size() > 0)
    begin
      void'(txq.pop_front());
      if (txq.size() > 0) tx_data <= byte_t'(txq[0]);
    end
    if (cfg_wr_valid === 1'b1)
      check("store", {cfg_wr_addr, cfg_wr_data},
            wrq.size() ? 16'(wrq.pop_front()) : 16'hxxxx);
    if (rx_valid === 1'b1)
      check("read", {8'h00, rx_data},
            rxq.size() ? 16'(rxq.pop_front()) : 16'hxxxx);
  end
  // Watchdog, above the roughly 83000 cycles the frames take
  initial
  begin
    repeat (95000) @(posedge mclk);
    num_errors++;
    test_done();
  end
  // Main sequence
  initial
  begin
    seed = 96621;
    num_errors = 0;
    total_checks = 0;
    fd_cnt = 0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_rd = 1'b0;
    cmd_id = TID;
    cmd_ptr = 8'h00;
    cmd_len = 8'h00;
    tx_data = 8'h00;
    foreach (mem[k]) mem[k] = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 3; i++)
    begin
      ptr = (i == 0) ? 8'hfe : 8'($random(seed));
      len = 8'((i + 2) % 3 + 1);
      for (int k = 0; k < len; k++)
      begin
        b = $random(seed) & 255;
        a = (ptr + k) % 256;
        mem[a] = b;
        txq.push_back(b);
        wrq.push_back(a * 256 + b);
      end
      run_cmd(1'b0, TID, ptr, len);
      for (int k = 0; k < len; k++) rxq.push_back(mem[(ptr + k) % 256]);
      run_cmd(1'b1, TID, ptr, len);
      check("nack", nack_err, 1'b0);
      check("left", 16'(wrq.size() + rxq.size()), 16'h0000);
      $display("Test write and read %0d done", i);
    end
    txq.push_back(8'h5a);
    run_cmd(1'b0, TID ^ 7'h01, 8'h10, 8'h01);
    check("foreign nack", nack_err, 1'b1);
    txq.delete();
    rxq.push_back(mem[16]);
    run_cmd(1'b1, TID, 8'h10, 8'h01);
    check("own nack", nack_err, 1'b0);
    run_cmd(1'b0, TID, 8'h20, 8'h00);
    check("pointer only", nack_err, 1'b0);
    $display("Test foreign and pointer frames done");
    test_done();
  end
endmodule : tb_top
